/* hrf_pkg.sv */
// package with constants shared by the hall result formatting block
package hrf_pkg;
  // register read indices
  localparam logic [2:0] HRF_IDX_X = 3'h0;
  localparam logic [2:0] HRF_IDX_Y = 3'h1;
  localparam logic [2:0] HRF_IDX_Z = 3'h2;
  localparam logic [2:0] HRF_IDX_TEMP = 3'h3;
  localparam logic [2:0] HRF_IDX_OFS = 3'h4;
  // conversion source codes
  localparam logic [1:0] HRF_SRC_X = 2'h0;
  localparam logic [1:0] HRF_SRC_Y = 2'h1;
  localparam logic [1:0] HRF_SRC_Z = 2'h2;
  localparam logic [1:0] HRF_SRC_TEMP = 2'h3;
  // axis pair select codes
  localparam logic [1:0] HRF_PAIR_NONE = 2'h0;
  localparam logic [1:0] HRF_PAIR_XY = 2'h1;
  localparam logic [1:0] HRF_PAIR_YZ = 2'h2;
  localparam logic [1:0] HRF_PAIR_XZ = 2'h3;
  // field layout of the offset correction register
  localparam int HRF_OFS_SEL_LSB = 14;
  localparam int HRF_OFS_T1_LSB = 7;
  localparam int HRF_OFS_T2_LSB = 0;
  localparam int HRF_TERM_W = 7;
  localparam int HRF_PAD_W = 4;
  // reset values
  localparam logic [15:0] HRF_RESULT_RST = 16'h0000;
  localparam logic [15:0] HRF_OFS_RST = 16'h0000;
  // frame-content select value for an ordinary register read
  localparam logic [2:0] HRF_FRAME_REGULAR = 3'h0;
  localparam logic [15:0] HRF_MAX_POS = 16'h7fff;
  localparam logic [15:0] HRF_MAX_NEG = 16'h8000;
endpackage

/* hrf_offset_sat.sv */
// offset term scaling and saturating add for one axis result
`timescale 1ns/1ps
module hrf_offset_sat
  import hrf_pkg::*;
(
  // operands
  input wire logic [15:0] value,
  input wire logic [6:0] term,
  input wire logic apply,
  // corrected result
  output logic [15:0] result
);
  logic [15:0] term_ext;
  logic [16:0] sum;

  // sign extend and scale the term, add, clamp on overflow
  always_comb
  begin
    term_ext = {{(16-HRF_TERM_W-HRF_PAD_W){term[6]}}, term,
                {HRF_PAD_W{1'b0}}};
    sum = {value[15], value} + {term_ext[15], term_ext};
    if (!apply)
      result = value;
    else if (sum[16] != sum[15])
      result = sum[16] ? HRF_MAX_NEG : HRF_MAX_POS;
    else
      result = sum[15:0];
  end
endmodule

/* hrf_result_format.sv */
// result registers, formatting and offset correction of the hall sensor
`timescale 1ns/1ps
// What this block does
// - separate result register for each axis
// - axis results are 16-bit two's complement
// - no averaging: 12-bit code, four zero bits
// - averaging on: all sixteen bits from converter
// - frame select zero returns full axis result
// - temperature stored as 16-bit value
// - offset correction on selected axis pair
// - add offset terms to selected axes
// - offset correction register resets to zero
// - offset terms are 7-bit two's complement
// - offset step fixed at sixteen result LSBs
// - frame select zero gives ordinary read
module hrf_result_format
  import hrf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // conversion results from the converter
  input wire logic conv_valid,
  input wire logic [1:0] conv_source,
  input wire logic [15:0] conv_data,
  // mode selects
  input wire logic [1:0] averaging_select,
  input wire logic [1:0] axis_pair_select,
  input wire logic [2:0] frame_content_select,
  // offset correction register write
  input wire logic ofs_wr_en,
  input wire logic [15:0] ofs_wr_data,
  // register read
  input wire logic rd_en,
  input wire logic [2:0] rd_index,
  output logic [15:0] rd_data,
  output logic [15:0] frame_data,
  // result registers and offset correction register
  output logic [15:0] x_axis_field_result,
  output logic [15:0] y_axis_field_result,
  output logic [15:0] z_axis_field_result,
  output logic [15:0] thermal_reading,
  output logic [15:0] field_offset_correction
);
  import hrf_pkg::*;

  logic [15:0] x_reg, x_next;
  logic [15:0] y_reg, y_next;
  logic [15:0] z_reg, z_next;
  logic [15:0] temp_reg, temp_next;
  logic [15:0] ofs_reg, ofs_next;
  logic [15:0] rd_reg, rd_next;
  logic [15:0] frame_reg, frame_next;
  logic [15:0] fmt_axis, x_cor, y_cor, z_cor;
  logic [1:0] ofs_sel;
  logic [6:0] term1, term2, y_term;
  logic x_app, y_app, z_app;

  // place the converter code into the 16-bit result layout
  function automatic logic [15:0] fmt_code(input logic [15:0] code,
                                           input logic [1:0] avg);
    if (avg == 2'h0)
      fmt_code = {code[11:0], {HRF_PAD_W{1'b0}}};
    else
      fmt_code = code;
  endfunction

  // register index decode, used by both read paths
  function automatic logic [15:0] pick(input logic [2:0] idx,
                                       input logic [15:0] xv,
                                       input logic [15:0] yv,
                                       input logic [15:0] zv,
                                       input logic [15:0] tv,
                                       input logic [15:0] ov);
    case (idx)
      HRF_IDX_X: pick = xv;
      HRF_IDX_Y: pick = yv;
      HRF_IDX_Z: pick = zv;
      HRF_IDX_TEMP: pick = tv;
      HRF_IDX_OFS: pick = ov;
      default: pick = 16'h0000;
    endcase
  endfunction

  // offset fields and which axis takes which term
  always_comb
  begin
    ofs_sel = ofs_reg[HRF_OFS_SEL_LSB +: 2];
    term1 = ofs_reg[HRF_OFS_T1_LSB +: HRF_TERM_W];
    term2 = ofs_reg[HRF_OFS_T2_LSB +: HRF_TERM_W];
    fmt_axis = fmt_code(conv_data, averaging_select);
    // first axis of the pair takes term1, second takes term2
    x_app = ofs_sel[0] && (axis_pair_select == HRF_PAIR_XY ||
                           axis_pair_select == HRF_PAIR_XZ);
    y_app = (ofs_sel[1] && axis_pair_select == HRF_PAIR_XY) ||
            (ofs_sel[0] && axis_pair_select == HRF_PAIR_YZ);
    y_term = (axis_pair_select == HRF_PAIR_YZ) ? term1 : term2;
    z_app = ofs_sel[1] && (axis_pair_select == HRF_PAIR_YZ ||
                           axis_pair_select == HRF_PAIR_XZ);
  end

  // one corrector per axis
  hrf_offset_sat u_x_cor
  (
    .value(fmt_axis),
    .term(term1),
    .apply(x_app),
    .result(x_cor)
  );

  hrf_offset_sat u_y_cor
  (
    .value(fmt_axis),
    .term(y_term),
    .apply(y_app),
    .result(y_cor)
  );

  hrf_offset_sat u_z_cor
  (
    .value(fmt_axis),
    .term(term2),
    .apply(z_app),
    .result(z_cor)
  );

  // next values of result, offset and read registers
  always_comb
  begin
    x_next = x_reg;
    y_next = y_reg;
    z_next = z_reg;
    temp_next = temp_reg;
    ofs_next = ofs_reg;
    rd_next = rd_reg;
    frame_next = frame_reg;
    if (conv_valid)
    begin
      unique case (conv_source)
        HRF_SRC_X: x_next = x_cor;
        HRF_SRC_Y: y_next = y_cor;
        HRF_SRC_Z: z_next = z_cor;
        // no averaging keeps the 12-bit code right aligned
        HRF_SRC_TEMP: temp_next = (averaging_select == 2'h0) ?
                        {4'h0, conv_data[11:0]} : conv_data;
      endcase
    end
    if (ofs_wr_en)
      ofs_next = ofs_wr_data;
    if (rd_en)
    begin
      rd_next = pick(rd_index, x_reg, y_reg, z_reg, temp_reg, ofs_reg);
      // ordinary read carries the whole register in the frame
      if (frame_content_select == HRF_FRAME_REGULAR)
        frame_next = rd_next;
      else
        frame_next = 16'h0000;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      x_reg <= HRF_RESULT_RST;
      y_reg <= HRF_RESULT_RST;
      z_reg <= HRF_RESULT_RST;
      temp_reg <= HRF_RESULT_RST;
      ofs_reg <= HRF_OFS_RST;
      rd_reg <= HRF_RESULT_RST;
      frame_reg <= HRF_RESULT_RST;
    end
    else
    begin
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      temp_reg <= temp_next;
      ofs_reg <= ofs_next;
      rd_reg <= rd_next;
      frame_reg <= frame_next;
    end
  end

  // outputs straight from flops
  assign x_axis_field_result = x_reg;
  assign y_axis_field_result = y_reg;
  assign z_axis_field_result = z_reg;
  assign thermal_reading = temp_reg;
  assign field_offset_correction = ofs_reg;
  assign rd_data = rd_reg;
  assign frame_data = frame_reg;

  // checks on formatting, correction and read paths
  a_zero_pad_low: assert property (@(posedge clk) disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_X && averaging_select == 2'h0
    && !x_app |=> x_reg == {$past(conv_data[11:0]), 4'h0})
    else $error("x result not zero padded");

  a_full_width: assert property (@(posedge clk) disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_Y && averaging_select != 2'h0
    && !y_app |=> y_reg == $past(conv_data))
    else $error("y result not full width");

  a_axis_separate: assert property (@(posedge clk)
    disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_Z |=> $stable(x_reg)
    && $stable(y_reg) && $stable(temp_reg))
    else $error("z conversion disturbed another register");

  a_temp_store: assert property (@(posedge clk) disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_TEMP && averaging_select != 2'h0
    |=> temp_reg == $past(conv_data))
    else $error("temperature not stored");

  a_ofs_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !ofs_wr_en |=> ofs_reg == $past(ofs_reg))
    else $error("offset register changed without write");

  a_x_offset_add: assert property (@(posedge clk)
    disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_X && averaging_select != 2'h0
    && x_app && conv_data[15:12] == 4'h0 |=> x_reg ==
    16'($past(conv_data) + {{5{$past(term1[6])}}, $past(term1), 4'h0}))
    else $error("x offset not added");

  a_sat_positive: assert property (@(posedge clk)
    disable iff (!rst_n)
    conv_valid && conv_source == HRF_SRC_X && x_app && !fmt_axis[15]
    && !term1[6] |=> !x_reg[15])
    else $error("positive correction wrapped");

  a_frame_regular: assert property (@(posedge clk)
    disable iff (!rst_n)
    rd_en && frame_content_select == HRF_FRAME_REGULAR
    && rd_index == HRF_IDX_X |=> frame_data == $past(x_reg)
    && rd_data == frame_data)
    else $error("regular frame lost axis result");

  a_unmapped_zero: assert property (@(posedge clk)
    disable iff (!rst_n)
    rd_en && rd_index > HRF_IDX_OFS |=> rd_data == 16'h0000)
    else $error("unmapped index not zero");
endmodule

/* hrf_host_model.sv */
// controller-side model issuing one-cycle register read requests
`timescale 1ns/1ps
module hrf_host_model
(
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic req,
  input wire logic [2:0] idx,
  // read strobe toward the block
  output logic rd_en,
  output logic [2:0] rd_index
);
  // launch a read just after the edge that sees the request
  always_ff @(posedge clk)
  begin
    rd_en <= req;
    rd_index <= req ? idx : ~rd_index; // index toggles when idle
  end
endmodule

/* tb_hrf_result_format.sv */
// self-checking bench for the hall result formatting block
`timescale 1ns/1ps
module tb_hrf_result_format;
  import hrf_pkg::*;
  logic clk = 0, rst_n = 0, conv_valid = 0, ofs_wr_en = 0, req = 0;
  logic [1:0] conv_source = 0, averaging_select = 0, axis_pair_select = 0;
  logic [2:0] frame_content_select = 0, idx = 0, rd_index;
  logic [15:0] conv_data = 0, ofs_wr_data = 0, rd_data, frame_data;
  logic [15:0] xr, yr, zr, tr, ofs;
  logic rd_en;
  int errors = 0, num_checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  hrf_host_model host (.clk(clk), .req(req), .idx(idx), .rd_en(rd_en),
    .rd_index(rd_index));
  hrf_result_format uut (.clk(clk), .rst_n(rst_n), .conv_valid(conv_valid),
    .conv_source(conv_source), .conv_data(conv_data),
    .averaging_select(averaging_select), .axis_pair_select(axis_pair_select),
    .frame_content_select(frame_content_select), .ofs_wr_en(ofs_wr_en),
    .ofs_wr_data(ofs_wr_data), .rd_en(rd_en), .rd_index(rd_index),
    .rd_data(rd_data), .frame_data(frame_data), .x_axis_field_result(xr),
    .y_axis_field_result(yr), .z_axis_field_result(zr),
    .thermal_reading(tr), .field_offset_correction(ofs));
  // compare and count
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // one conversion word, result settled on return
  task conv(input logic [1:0] s, input logic [15:0] d);
    @(posedge clk);
    conv_valid <= 1;
    conv_source <= s;
    conv_data <= d;
    @(posedge clk);
    conv_valid <= 0;
    #1;
  endtask
  // offset register write
  task wr_ofs(input logic [15:0] w);
    @(posedge clk);
    ofs_wr_en <= 1;
    ofs_wr_data <= w;
    @(posedge clk);
    ofs_wr_en <= 0;
    #1;
  endtask
  // set mode selects
  task mode(input logic [1:0] a, input logic [1:0] p, input logic [2:0] f);
    @(posedge clk);
    averaging_select <= a;
    axis_pair_select <= p;
    frame_content_select <= f;
  endtask
  // read through the controller model
  task rd(input logic [2:0] i);
    @(posedge clk);
    req <= 1;
    idx <= i;
    @(posedge clk);
    req <= 0;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] axis(input int a);
    return a == 0 ? xr : a == 1 ? yr : zr;
  endfunction
  task t_reset_values;
    chk("x", 16'h0000, xr);
    chk("temp", 16'h0000, tr);
    chk("offset reg", 16'h0000, ofs);
  endtask
  task t_formatting;
    conv(HRF_SRC_X, 16'h0abc);
    chk("x pad", 16'habc0, xr);
    chk("y kept", 16'h0000, yr);
    conv(HRF_SRC_TEMP, 16'hf447);
    chk("temp short", 16'h0447, tr);
    mode(2'h1, HRF_PAIR_NONE, 3'h0);
    conv(HRF_SRC_Z, 16'h8001);
    chk("z full", 16'h8001, zr);
    chk("x kept", 16'habc0, xr);
    conv(HRF_SRC_X, 16'h028e);
    chk("x one mT", 16'h028e, xr);
    conv(HRF_SRC_TEMP, 16'h4472);
    chk("temp full", 16'h4472, tr);
  endtask
  task t_pairs;
    logic [15:0] e;
    wr_ofs({2'b11, 7'h01, 7'h7f});
    chk("offset reg", 16'hc0ff, ofs);
    for (int p = 3; p >= 0; p--)
    begin
      mode(2'h1, p[1:0], 3'h0);
      for (int a = 0; a < 3; a++)
      begin
        conv(a[1:0], 16'h0800);
        e = 16'h0800;
        if ((p == 1 || p == 3) && a == 0 || p == 2 && a == 1)
          e = 16'h0810;
        if (p == 1 && a == 1 || (p == 2 || p == 3) && a == 2)
          e = 16'h07f0;
        chk("pair axis", e, axis(a));
      end
    end
  endtask
  task t_extremes;
    mode(2'h0, HRF_PAIR_XY, 3'h0);
    wr_ofs({2'b11, 7'h3f, 7'h40});
    conv(HRF_SRC_X, 16'h0100);
    chk("x max term", 16'h13f0, xr);
    conv(HRF_SRC_Y, 16'h0100);
    chk("y min term", 16'h0c00, yr);
    mode(2'h1, HRF_PAIR_XY, 3'h0);
    conv(HRF_SRC_Y, 16'h8100);
    chk("y sat", 16'h8000, yr);
    conv(HRF_SRC_X, 16'h7ff0);
    chk("x sat", 16'h7fff, xr);
    wr_ofs({2'b01, 7'h3f, 7'h40});
    conv(HRF_SRC_Y, 16'h1000);
    chk("y unselected", 16'h1000, yr);
  endtask
  task t_reads;
    rd(HRF_IDX_X);
    chk("rd x", 16'h7fff, rd_data);
    chk("frame x", 16'h7fff, frame_data);
    rd(HRF_IDX_OFS);
    chk("rd offset", 16'h5fc0, rd_data);
    rd(HRF_IDX_Z);
    chk("rd z", 16'h0800, rd_data);
    chk("frame z", 16'h0800, frame_data);
    rd(HRF_IDX_TEMP);
    chk("rd temp", 16'h4472, rd_data);
    mode(2'h1, HRF_PAIR_XY, 3'h1);
    rd(HRF_IDX_Y);
    chk("rd y", 16'h1000, rd_data);
    chk("frame special", 16'h0000, frame_data);
    rd(3'h7);
    chk("rd unmapped", 16'h0000, rd_data);
  endtask
  task complete_run;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    t_reset_values;
    rst_n <= 1;
    t_formatting;
    t_pairs;
    t_extremes;
    t_reads;
    complete_run;
  end
endmodule
